//--- include/csi_regs.svh
// Offsets, field positions and reset values of the common status register
`ifndef CSI_REGS_SVH
`define CSI_REGS_SVH

// Command byte that selects the common status register
`define CSI_CMD_COMMON_STATUS 8'h06

// Field positions inside the common status byte
`define CSI_BIT_RSVD_HI       7
`define CSI_BIT_RSVD_LO       6
`define CSI_BIT_GP_B          5
`define CSI_BIT_GP_A          4
`define CSI_BIT_IRQ_MASK      3
`define CSI_BIT_UV            2
`define CSI_BIT_OT            1
`define CSI_BIT_UNDEF         0

// Power-up values
`define CSI_RESET_COMMON      8'h00
`define CSI_RESET_MASK        1'b0
`define CSI_RESET_FLAG        1'b0
`define CSI_RESET_RSVD        2'h0
`define CSI_RESET_UNDEF       1'b0

`endif

//--- include/csi_pkg.sv
// Types shared by the common status register design
package csi_pkg;

  // One register byte on the command port
  typedef logic [7:0] csi_byte_t;

  // Index of each sticky fault flag; flag i sits at bit CSI_BIT_OT + i
  typedef enum logic [0:0] {
    csi_flag_ot,
    csi_flag_uv
  } csi_flag_t;

  localparam int CSI_NUM_FLAGS = 2;

endpackage : csi_pkg

//--- design/csi_sticky_flag.sv
// Sticky fault flag: set on a rising fault condition, cleared by write-one
`timescale 1ns/10ps
module csi_sticky_flag (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic fault_cond,
  input  wire logic clr_req,
  output logic      flag
);
  import csi_pkg::*;
  `include "csi_regs.svh"

  logic prev_reg;
  logic prev_next;
  logic flag_reg;
  logic flag_next;
  logic set_evt;

  // Edge detect so a held fault does not re-arm right after a clear
  always_comb begin
    set_evt   = fault_cond & ~prev_reg;
    prev_next = fault_cond;
    // Set wins over a clear in the same cycle
    flag_next = set_evt | (flag_reg & ~clr_req);
  end

  // Registers frozen while the clock enable is low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_reg <= 1'b0;
      flag_reg <= `CSI_RESET_FLAG;
    end else if (ce) begin
      prev_reg <= prev_next;
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_flag_set;
    ce && fault_cond && !prev_reg |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("fault edge did not set flag"); // R06

  property p_flag_clear;
    ce && clr_req && !(fault_cond && !prev_reg) |=> !flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write-one did not clear flag"); // R11

  property p_flag_hold;
    ce && !clr_req && flag |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a clear"); // R11

endmodule : csi_sticky_flag

//--- design/csi_common_status.sv
// Common status register: pin levels, interrupt mask, sticky fault flags
//
// Functional notes
// R01: Bits 7 and 6 always read as zero whatever was written to them.
// R02: Bit 5 is read-only and shows the live slot B general-purpose input level.
// R03: Bit 4 is read-only and shows the live slot A general-purpose input level.
// R04: Mask bit 3 clear lets the active-low interrupt drive; set, it suppresses it.
// R05: While the mask bit is set the device takes no part in alert-response arbitration.
// R06: Bit 2 is set when a supply lockout on a main input causes a breaker fault.
// R07: The undervoltage flag only sets when a slot's main enable pin or control bit is on.
// R08: Bit 1 is set on an over-temperature indication and stays clear without one.
// R09: After reset the register holds all zeros: unmasked, both flags clear.
// R10: Command byte 06h selects this register for reads and writes.
// R11: Writing 1 to a fault flag clears it; writing 0 leaves it unchanged.
// R12: Clearing the last enabled flag releases the interrupt output.
// R13: Bit 0 is undefined on reads and ignores writes.
// R14: Writes to the input bits are ignored; they keep showing the pins.
`timescale 1ns/10ps
module csi_common_status (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic [7:0]         reg_cmd,
  input  wire logic               reg_wr_en,
  input  wire csi_pkg::csi_byte_t reg_wr_data,
  input  wire logic               reg_rd_en,
  output csi_pkg::csi_byte_t      reg_rd_data,
  output logic                    reg_rd_valid,
  output logic                    reg_cmd_hit,
  input  wire logic               slot_a_gp_input,
  input  wire logic               slot_b_gp_input,
  input  wire logic [1:0]         supply_lockout,
  input  wire logic [1:0]         slot_main_pin_en,
  input  wire logic [1:0]         slot_main_ctrl_bit,
  input  wire logic               overtemp_event,
  input  wire logic               ara_poll,
  output logic                    ara_ack,
  output logic                    irq_out,
  output logic                    irq_oe_n
);
  import csi_pkg::*;
  `include "csi_regs.svh"

  logic                     mask_reg;
  logic                     mask_next;
  csi_byte_t                rd_data_reg;
  csi_byte_t                rd_data_next;
  logic                     rd_valid_reg;
  logic                     rd_valid_next;
  logic                     ara_ack_reg;
  logic                     ara_ack_next;
  logic                     wr_hit;
  logic                     uv_cond;
  logic                     irq_active;
  csi_byte_t                status_image;
  logic [CSI_NUM_FLAGS-1:0] fault_cond;
  logic [CSI_NUM_FLAGS-1:0] flag_clr;
  logic [CSI_NUM_FLAGS-1:0] flag_val;

  // Command decode; other command bytes belong to other registers
  // R10: decode command 06h
  assign reg_cmd_hit = (reg_cmd == `CSI_CMD_COMMON_STATUS);
  assign wr_hit      = reg_wr_en & reg_cmd_hit;

  // Lockout only counts while some slot is asking for main power
  // R06: lockout raises flag
  // R07: only with slot main on
  assign uv_cond = (|supply_lockout) & (|(slot_main_pin_en | slot_main_ctrl_bit));

  // Fault sources and write-one clears, indexed like the flag enum
  // R08: overtemperature source
  assign fault_cond[csi_flag_ot] = overtemp_event;
  assign fault_cond[csi_flag_uv] = uv_cond;

  // One sticky cell per fault flag; bit position follows the index
  genvar gi;
  generate
    for (gi = 0; gi < CSI_NUM_FLAGS; gi++) begin : g_flag
      // R11: write one clears
      assign flag_clr[gi] = wr_hit & reg_wr_data[`CSI_BIT_OT + gi];
      csi_sticky_flag u_flag (
        .core_clk   (core_clk),
        .rst        (rst),
        .ce         (ce),
        .fault_cond (fault_cond[gi]),
        .clr_req    (flag_clr[gi]),
        .flag       (flag_val[gi])
      );
    end
  endgenerate

  // Read image; undefined bit 0 is driven low to keep reads deterministic
  // R01: reserved bits zero
  // R02: live slot B pin
  // R03: live slot A pin
  // R13: bit 0 undefined
  always_comb begin
    status_image                     = `CSI_RESET_COMMON;
    status_image[`CSI_BIT_RSVD_HI:`CSI_BIT_RSVD_LO] = `CSI_RESET_RSVD;
    status_image[`CSI_BIT_GP_B]      = slot_b_gp_input;
    status_image[`CSI_BIT_GP_A]      = slot_a_gp_input;
    status_image[`CSI_BIT_IRQ_MASK]  = mask_reg;
    status_image[`CSI_BIT_UV]        = flag_val[csi_flag_uv];
    status_image[`CSI_BIT_OT]        = flag_val[csi_flag_ot];
    status_image[`CSI_BIT_UNDEF]     = `CSI_RESET_UNDEF;
  end

  // Interrupt requested while any flag is set and the mask is clear
  // R04: mask gates interrupt
  // R12: release after last clear
  assign irq_active = ~mask_reg & (|flag_val);

  // Next values: only mask is writable; pin bits and bit 0 drop writes
  // R14: input bits ignore writes
  always_comb begin
    mask_next     = mask_reg;
    rd_data_next  = rd_data_reg;
    rd_valid_next = 1'b0;
    ara_ack_next  = 1'b0;
    if (wr_hit) begin
      mask_next = reg_wr_data[`CSI_BIT_IRQ_MASK];
    end
    if (reg_rd_en && reg_cmd_hit) begin
      rd_data_next  = status_image;
      rd_valid_next = 1'b1;
    end
    // R05: masked device stays out of alert response
    if (ara_poll && irq_active) begin
      ara_ack_next = 1'b1;
    end
  end

  // R09: all zero after reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_reg     <= `CSI_RESET_MASK;
      rd_data_reg  <= `CSI_RESET_COMMON;
      rd_valid_reg <= 1'b0;
      ara_ack_reg  <= 1'b0;
    end else if (ce) begin
      mask_reg     <= mask_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      ara_ack_reg  <= ara_ack_next;
    end
  end

  // Open-drain interrupt: value is always low, enable low pulls the line
  assign irq_out      = 1'b0;
  assign irq_oe_n     = ~irq_active;
  assign reg_rd_data  = rd_data_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign ara_ack      = ara_ack_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_rsvd_zero;
    reg_rd_valid |-> reg_rd_data[`CSI_BIT_RSVD_HI:`CSI_BIT_RSVD_LO] == 2'h0 && !reg_rd_data[`CSI_BIT_UNDEF];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero"); // R01

  property p_gp_b_live;
    ce && reg_rd_en && reg_cmd_hit |=> reg_rd_data[`CSI_BIT_GP_B] == $past(slot_b_gp_input);
  endproperty
  a_gp_b_live: assert property (p_gp_b_live) else $error("slot B input bit wrong"); // R02

  property p_gp_a_live;
    ce && reg_rd_en && reg_cmd_hit && !wr_hit |=> reg_rd_data[`CSI_BIT_GP_A] == $past(slot_a_gp_input);
  endproperty
  a_gp_a_live: assert property (p_gp_a_live) else $error("slot A input bit wrong"); // R03

  property p_mask_blocks_irq;
    ce && wr_hit && reg_wr_data[`CSI_BIT_IRQ_MASK] |=> irq_oe_n;
  endproperty
  a_mask_blocks_irq: assert property (p_mask_blocks_irq) else $error("masked device drove interrupt"); // R04

  property p_irq_follows_flag;
    !mask_reg && flag_val[csi_flag_ot] |-> !irq_oe_n;
  endproperty
  a_irq_follows_flag: assert property (p_irq_follows_flag) else $error("unmasked flag not on interrupt"); // R04

  property p_no_ara_masked;
    ce && ara_poll && mask_reg |=> !ara_ack;
  endproperty
  a_no_ara_masked: assert property (p_no_ara_masked) else $error("masked device joined alert response"); // R05

  property p_uv_needs_slot;
    ce && !flag_val[csi_flag_uv] && !(|(slot_main_pin_en | slot_main_ctrl_bit)) |=> !flag_val[csi_flag_uv];
  endproperty
  a_uv_needs_slot: assert property (p_uv_needs_slot) else $error("undervoltage set with no slot on"); // R07

  property p_ot_sets;
    ce && $rose(overtemp_event) ##1 ce && reg_rd_en && reg_cmd_hit |=> reg_rd_data[`CSI_BIT_OT];
  endproperty
  a_ot_sets: assert property (p_ot_sets) else $error("overtemperature flag not read back"); // R08

  property p_reset_zero;
    $past(rst) |-> !mask_reg && flag_val == 2'h0 && irq_oe_n && reg_rd_data == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset"); // R09

  property p_cmd_decode;
    ce && reg_rd_en && reg_cmd != `CSI_CMD_COMMON_STATUS |=> !reg_rd_valid;
  endproperty
  a_cmd_decode: assert property (p_cmd_decode) else $error("wrong command answered"); // R10

  property p_release_irq;
    ce && wr_hit && reg_wr_data[`CSI_BIT_UV:`CSI_BIT_OT] == 2'h3 && !fault_cond[0] && !fault_cond[1] |=> irq_oe_n;
  endproperty
  a_release_irq: assert property (p_release_irq) else $error("interrupt held after clearing flags"); // R12

  property p_ara_joins;
    ce && ara_poll && irq_active |=> ara_ack;
  endproperty
  a_ara_joins: assert property (p_ara_joins) else $error("unmasked alert not answered"); // R05

  property p_rd_answer;
    ce && reg_rd_en && reg_cmd_hit |=> reg_rd_valid && reg_rd_data == $past(status_image);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle"); // R10

  c_uv_irq: cover property (ce && $rose(uv_cond) ##1 !irq_oe_n);
  c_clear_flag: cover property (flag_val[csi_flag_ot] ##1 ce && flag_clr[csi_flag_ot] ##1 !flag_val[csi_flag_ot]);
  c_ara_ack: cover property (ara_ack);
  c_masked_flag: cover property (ce && mask_reg && flag_val[csi_flag_ot] && irq_oe_n);

endmodule : csi_common_status

//--- sim/csi_host_model.sv
// Host-side model of the command-byte register port and alert poll
`timescale 1ns/10ps
module csi_host_model (
  input  wire logic               core_clk,
  output logic [7:0]              reg_cmd,
  output logic                    reg_wr_en,
  output csi_pkg::csi_byte_t      reg_wr_data,
  output logic                    reg_rd_en,
  input  wire csi_pkg::csi_byte_t reg_rd_data,
  input  wire logic               reg_rd_valid,
  output logic                    ara_poll,
  input  wire logic               ara_ack
);
  import csi_pkg::*;

  // Idle bus at time zero, no strobe before reset ends
  initial begin
    reg_cmd     = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
    ara_poll    = 1'b0;
  end

  task automatic wr(input logic [7:0] cmd, input csi_byte_t d);
    @(negedge core_clk);
    reg_cmd     = cmd;
    reg_wr_data = d;
    reg_wr_en   = 1'b1;
    @(negedge core_clk);
    reg_wr_en   = 1'b0;
    reg_wr_data = ~d; // Stale data must not look valid
  endtask : wr

  task automatic rd(input logic [7:0] cmd, output csi_byte_t d, output logic v);
    @(negedge core_clk);
    reg_cmd   = cmd;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    d         = reg_rd_data; // Valid stands only this cycle; data holds until the next 06h read
    v         = reg_rd_valid;
  endtask : rd

  // Alert response poll, answer one cycle later
  task automatic ara(output logic ack);
    @(negedge core_clk);
    ara_poll = 1'b1;
    @(negedge core_clk);
    ara_poll = 1'b0;
    ack      = ara_ack;
  endtask : ara
endmodule : csi_host_model

//--- sim/tb_top.sv
// Self-checking bench for the common status register
`timescale 1ns/10ps
`include "csi_regs.svh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  import csi_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic       gp_a     = 1'b0;
  logic       gp_b     = 1'b0;
  logic [1:0] lockout  = 2'b00;
  logic [1:0] pin_en   = 2'b00;
  logic [1:0] ctrl     = 2'b00;
  logic       ot_ev    = 1'b0;
  logic       ce       = 1'b1;
  logic [7:0] cmd;
  logic       wr_en;
  csi_byte_t  wr_data;
  logic       rd_en;
  csi_byte_t  rd_data;
  logic       rd_valid;
  logic       cmd_hit;
  logic       poll;
  logic       ack;
  logic       irq_out;
  logic       irq_oe_n;
  logic       a;
  csi_byte_t  rd_exp_d;
  int         mismatches = 0;
  int         n_checks   = 0;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // Clock enable driven by the bench so freezing is exercised
  csi_common_status i_csi_common_status (
    .core_clk(core_clk), .rst(rst), .ce(ce), .reg_cmd(cmd), .reg_wr_en(wr_en), .reg_wr_data(wr_data),
    .reg_rd_en(rd_en), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .reg_cmd_hit(cmd_hit),
    .slot_a_gp_input(gp_a), .slot_b_gp_input(gp_b), .supply_lockout(lockout), .slot_main_pin_en(pin_en),
    .slot_main_ctrl_bit(ctrl), .overtemp_event(ot_ev), .ara_poll(poll), .ara_ack(ack), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n));

  csi_host_model i_csi_host_model (
    .core_clk(core_clk), .reg_cmd(cmd), .reg_wr_en(wr_en), .reg_wr_data(wr_data), .reg_rd_en(rd_en),
    .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .ara_poll(poll), .ara_ack(ack));

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Read the register and compare the whole byte
  task automatic rd_exp(input csi_byte_t e);
    csi_byte_t d;
    logic      v;
    i_csi_host_model.rd(`CSI_CMD_COMMON_STATUS, d, v);
    `CHK("rd_valid", 1'b1, v)
    `CHK("rd_data", e, d)
    `CHK("cmd_hit", 1'b1, cmd_hit)
  endtask : rd_exp

  task automatic wr(input csi_byte_t d);
    i_csi_host_model.wr(`CSI_CMD_COMMON_STATUS, d);
  endtask : wr

  // Hang guard at 2000 cycles, far beyond the fewer than a hundred cycles used
  initial begin
    #(25 * 2000);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rd_exp(8'h00);
    `CHK("irq_oe_n", 1'b1, irq_oe_n)
    `CHK("irq_out", 1'b0, irq_out)
    // Pin levels survive writes of all ones to the read-only bits
    for (int i = 0; i < 4; i++) begin
      gp_a = i[0];
      gp_b = i[1];
      wr(8'hF1);
      rd_exp({2'b00, gp_b, gp_a, 4'h0});
    end
    gp_a = 1'b0;
    gp_b = 1'b0;
    ot_ev = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("irq_oe_n", 1'b0, irq_oe_n)
    i_csi_host_model.ara(a);
    `CHK("ara_ack", 1'b1, a)
    rd_exp(8'h02);
    wr(8'h00);
    rd_exp(8'h02);
    wr(8'h02);
    rd_exp(8'h00);
    `CHK("irq_oe_n", 1'b1, irq_oe_n)
    ot_ev = 1'b0;
    // Lockout with no slot on, then pin enable, then control bit
    for (int k = 0; k < 3; k++) begin
      pin_en = (k == 1) ? 2'b10 : 2'b00;
      ctrl   = (k == 2) ? 2'b01 : 2'b00;
      @(negedge core_clk);
      lockout = (k == 1) ? 2'b10 : 2'b01;
      repeat (2) @(negedge core_clk);
      rd_exp((k == 0) ? 8'h00 : 8'h04);
      `CHK("irq_oe_n", (k == 0), irq_oe_n)
      wr(8'h04);
      lockout = 2'b00;
    end
    // Masked: flag still sets, interrupt and alert stay quiet
    wr(8'h08);
    ot_ev = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("irq_oe_n", 1'b1, irq_oe_n)
    i_csi_host_model.ara(a);
    `CHK("ara_ack", 1'b0, a)
    rd_exp(8'h0A);
    wr(8'h0A);
    rd_exp(8'h08);
    ot_ev = 1'b0;
    // Frozen clock enable: strobes are lost, state holds; one idle edge first so valid drops
    @(negedge core_clk);
    ce = 1'b0;
    wr(8'h00);
    i_csi_host_model.rd(`CSI_CMD_COMMON_STATUS, rd_exp_d, a);
    `CHK("rd_valid_frozen", 1'b0, a)
    ce = 1'b1;
    rd_exp(8'h08);
    // A neighbouring command byte is not this register
    i_csi_host_model.rd(8'h05, rd_exp_d, a);
    `CHK("rd_valid", 1'b0, a)
    `CHK("rd_data_hold", 8'h08, rd_exp_d)
    `CHK("cmd_hit", 1'b0, cmd_hit)
    // Reset in mid-run returns every bit to zero
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    `CHK("irq_oe_n", 1'b1, irq_oe_n)
    rd_exp(8'h00);
    close_out();
  end
endmodule : tb_top
